//--- inc/framer_pkg.sv
/*
 * Constants and helper functions shared by the ASCII serial slave framer.
 * Assumes the byte-level serial receiver and transmitter sit outside the framer.
 */
package framer_pkg;

    // --------------------
    // Control codes
    // --------------------
    localparam logic [7:0] CODE_ENQ = 8'h05;
    localparam logic [7:0] CODE_ACK = 8'h06;
    localparam logic [7:0] CODE_NAK = 8'h15;
    localparam logic [7:0] CODE_EOT = 8'h04;
    localparam logic [7:0] CODE_ETX = 8'h03;

    // --------------------
    // Frame layout
    // --------------------
    localparam logic [8:0] MAX_FRAME = 9'h100;     // Whole frame, header to check
    localparam logic [8:0] ECHO_LEN = 9'h005;      // Station 2, command 1, type 2
    localparam logic [8:0] POS_BODY = 9'h006;      // First data position of a response
    localparam logic [8:0] ERR_CHARS = 9'h004;     // Error code in ASCII characters
    localparam logic [7:0] MAX_DATA = 8'hF7;       // Data that still fits one response
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // --------------------
    // Error codes sent for malformed requests (arbitrary values)
    // --------------------
    localparam logic [15:0] ERR_TOO_LONG = 16'h0101;
    localparam logic [15:0] ERR_SHORT = 16'h0102;
    localparam logic [15:0] ERR_CHECK = 16'h0103;

    // Nibble to ASCII hex digit, upper case
    function automatic logic [7:0] hex_char(input logic [3:0] n);
        hex_char = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction : hex_char

    // ASCII hex digit to {valid, value}
    function automatic logic [4:0] hex_value(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39)
        begin
            hex_value = {1'b1, c[3:0]};
        end
        else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
        begin
            hex_value = {1'b1, c[3:0] + 4'h9};
        end
        else
        begin
            hex_value = 5'h00;
        end
    endfunction : hex_value

    // Lower-case command letter selects a frame check
    function automatic logic is_lower(input logic [7:0] c);
        is_lower = (c >= 8'h61 && c <= 8'h7A);
    endfunction : is_lower

endpackage : framer_pkg

//--- hdl/frame_store.sv
/*
 * Byte memory holding the request data field and the response data.
 * Assumes one writer at a time, chosen by the framer; read data is registered.
 */
`timescale 1ns/1ns
module frame_store
    import framer_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Write port
    input wire logic we,
    input wire logic [7:0] waddr,
    input wire logic [7:0] wdata,
    // Read port
    input wire logic [7:0] raddr,
    output logic [7:0] rdata
);

    logic [7:0] mem [0:255];

    // Write side
    always_ff @(posedge clock)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            rdata <= RESET_BYTE;
        end
        else
        begin
            rdata <= mem[raddr];
        end
    end

endmodule : frame_store

//--- hdl/byte_buffer.sv
/*
 * Two-entry byte buffer with valid and ready on both sides.
 * Assumes the drain side may stall at any time; no byte is lost or repeated.
 */
`timescale 1ns/1ns
module byte_buffer
    import framer_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Fill side
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [7:0] out_data,
    input wire logic out_ready
);

    logic [1:0] count;
    logic [7:0] second;

    // Handshakes and where an incoming byte lands
    wire take = in_valid && in_ready;
    wire give = out_valid && out_ready;
    wire load_second = take && ((count == 2'h1 && !give) || (count == 2'h2 && give));
    wire load_first = take && (count == 2'h0 || (give && count == 2'h1));
    wire [1:0] next_count = count + {1'b0, take} - {1'b0, give};
    assign in_ready = (count != 2'h2);

    // Occupancy
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            count <= 2'h0;
            out_valid <= 1'b0;
        end
        else
        begin
            count <= next_count;
            out_valid <= next_count != 2'h0; // Head valid leaves a flip-flop
        end
    end

    // Data shift
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            out_data <= RESET_BYTE;
            second <= RESET_BYTE;
        end
        else
        begin
            if (give && count == 2'h2)
            begin
                out_data <= second;
            end
            else if (load_first)
            begin
                out_data <= in_data;
            end
            if (load_second)
            begin
                second <= in_data;
            end
        end
    end

endmodule : byte_buffer

//--- hdl/ascii_serial_slave_framer.sv
/*
 * Slave framer: checks request frames and builds ACK or NAK responses.
 * Assumes an outside byte receiver and transmitter and an answering application.
 */
`timescale 1ns/1ns

// What this block does
// RQ1: The master opens each request with ENQ, then station, command, type and data.
// RQ2: The master closes the request with EOT after the data and before any check.
// RQ3: A good request is answered with a frame that starts with ACK.
// RQ4: A bad request is answered with a frame that starts with NAK.
// RQ5: Every response ends with ETX ahead of any check characters.
// RQ6: A NAK response carries a four-character error code in place of data.
// RQ7: An ACK response carries the result data, or nothing when there is none.
// RQ8: An ACK response repeats station, command and command type in order.
// RQ9: A NAK response repeats station, command and command type in order.
// RQ10: Numeric fields travel as ASCII hexadecimal digits.
// RQ11: No frame may pass 256 bytes, and a longer request is treated as bad.
// RQ12: A lower-case command letter adds a check after the tail, upper case does not.
// RQ13: Channel 1 is point to point; channel 2 drives a shared bus only while answering.
// RQ14: The check is the low byte of the sum from header to tail, in two hex digits.
// RQ15: A request for another station number is ignored and not answered.
module ascii_serial_slave_framer
    import framer_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Configuration
    input wire logic [7:0] own_station,
    input wire logic chan2,
    // Received bytes
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    // Bytes to send
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic bus_drive_en,
    // Accepted request
    output logic req_valid,
    output logic [7:0] req_cmd,
    output logic [15:0] req_type,
    output logic [7:0] req_len,
    input wire logic [7:0] req_rd_addr,
    output logic [7:0] req_rd_data,
    // Answer from the application
    input wire logic ans_wr,
    input wire logic [7:0] ans_addr,
    input wire logic [7:0] ans_wdata,
    input wire logic ans_start,
    input wire logic ans_ok,
    input wire logic [7:0] ans_len,
    input wire logic [15:0] ans_err,
    output logic busy
);

    // --------------------
    // State
    // --------------------
    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_BODY = 6'h02,
        S_CHK_HI = 6'h04,
        S_CHK_LO = 6'h08,
        S_WAIT = 6'h10,
        S_SEND = 6'h20
    } state_e;

    state_e state;
    logic [8:0] frame_len;
    logic [8:0] body_len;
    logic [7:0] rx_sum;
    logic err_long;
    logic [4:0] chk_hi;
    logic [7:0] st_hi;
    logic [7:0] st_lo;
    logic [7:0] ct_hi;
    logic [7:0] ct_lo;
    logic nak;
    logic [15:0] err_code;
    logic [7:0] data_len;
    logic [8:0] pos;
    logic rd_ok;
    logic [7:0] tx_sum;

    logic buf_ready;
    logic [7:0] mem_rdata;

    // --------------------
    // Request decoding
    // --------------------
    wire got_enq = rx_valid && rx_data == CODE_ENQ; // RQ1
    wire got_eot = rx_valid && rx_data == CODE_EOT; // RQ2
    wire with_chk = is_lower(req_cmd); // RQ12
    wire [4:0] st_hi_v = hex_value(st_hi); // RQ10
    wire [4:0] st_lo_v = hex_value(st_lo); // RQ10
    wire [4:0] chk_lo = hex_value(rx_data);
    wire station_ok = body_len >= 9'h002 && st_hi_v[4] && st_lo_v[4]
        && {st_hi_v[3:0], st_lo_v[3:0]} == own_station; // RQ15
    wire chk_bad = !(chk_hi[4] && chk_lo[4] && {chk_hi[3:0], chk_lo[3:0]} == rx_sum); // RQ14
    wire in_body = state == S_BODY && rx_valid && !got_enq && !got_eot;
    wire finish = (state == S_BODY && got_eot && !with_chk) || (state == S_CHK_LO && rx_valid);
    wire is_short = body_len < ECHO_LEN;
    wire too_long = err_long || (rx_valid && frame_len == MAX_FRAME); // RQ11
    wire is_bad = too_long || is_short || (state == S_CHK_LO && chk_bad);
    wire [15:0] rx_err = too_long ? ERR_TOO_LONG : (is_short ? ERR_SHORT : ERR_CHECK);
    wire store_rx = in_body && !err_long && !is_short;
    wire [8:0] rx_addr = body_len - ECHO_LEN;

    // --------------------
    // Response byte selection
    // --------------------
    wire [8:0] body_n = nak ? ERR_CHARS : {1'b0, data_len};
    wire [8:0] pos_etx = POS_BODY + body_n;
    wire [8:0] last_pos = with_chk ? pos_etx + 9'h002 : pos_etx;
    wire [8:0] ofs = pos - POS_BODY;
    wire in_data = !nak && pos >= POS_BODY && pos < pos_etx;
    wire [3:0] err_nib = ofs[1:0] == 2'h0 ? err_code[15:12] :
        ofs[1:0] == 2'h1 ? err_code[11:8] :
        ofs[1:0] == 2'h2 ? err_code[7:4] : err_code[3:0];
    wire [7:0] tx_byte =
        pos == 9'h000 ? (nak ? CODE_NAK : CODE_ACK) : // RQ3 RQ4
        pos == 9'h001 ? st_hi : // RQ8 RQ9
        pos == 9'h002 ? st_lo :
        pos == 9'h003 ? req_cmd :
        pos == 9'h004 ? ct_hi :
        pos == 9'h005 ? ct_lo :
        pos < pos_etx ? (nak ? hex_char(err_nib) : mem_rdata) : // RQ6 RQ7
        pos == pos_etx ? CODE_ETX : // RQ5
        pos == pos_etx + 9'h001 ? hex_char(tx_sum[7:4]) : hex_char(tx_sum[3:0]); // RQ14
    wire push = state == S_SEND && buf_ready && (!in_data || rd_ok);

    // Memory sharing: receiver, application writes while waiting, sender reads
    wire mem_we = store_rx || (state == S_WAIT && ans_wr);
    wire [7:0] mem_waddr = state == S_WAIT ? ans_addr : rx_addr[7:0];
    wire [7:0] mem_wdata = state == S_WAIT ? ans_wdata : rx_data;
    wire [7:0] mem_raddr = state == S_SEND ? ofs[7:0] : req_rd_addr;
    wire [7:0] ans_fit = ans_len > MAX_DATA ? MAX_DATA : ans_len; // RQ11

    // --------------------
    // Storage and output buffer
    // --------------------
    frame_store store (
        .clock(clock),
        .srst(srst),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    byte_buffer out_buf (
        .clock(clock),
        .srst(srst),
        .in_valid(push),
        .in_data(tx_byte),
        .in_ready(buf_ready),
        .out_valid(tx_valid),
        .out_data(tx_data),
        .out_ready(tx_ready)
    );

    assign req_rd_data = mem_rdata;

    // --------------------
    // Frame sequencing
    // --------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state <= S_IDLE;
            frame_len <= 9'h000;
            body_len <= 9'h000;
            rx_sum <= RESET_BYTE;
            err_long <= 1'b0;
            chk_hi <= 5'h00;
            st_hi <= RESET_BYTE;
            st_lo <= RESET_BYTE;
            req_cmd <= RESET_BYTE;
            ct_hi <= RESET_BYTE;
            ct_lo <= RESET_BYTE;
            nak <= 1'b0;
            err_code <= 16'h0000;
            data_len <= RESET_BYTE;
            pos <= 9'h000;
            rd_ok <= 1'b0;
            tx_sum <= RESET_BYTE;
            req_valid <= 1'b0;
            req_len <= RESET_BYTE;
        end
        else
        begin
            req_valid <= 1'b0;
            case (state)
                S_IDLE, S_BODY, S_CHK_HI, S_CHK_LO:
                begin
                    // A fresh ENQ restarts reception in every state except S_WAIT and S_SEND
                    if (got_enq)
                    begin
                        state <= S_BODY; // RQ1
                        frame_len <= 9'h001;
                        body_len <= 9'h000;
                        rx_sum <= CODE_ENQ;
                        err_long <= 1'b0;
                        req_cmd <= RESET_BYTE;
                    end
                    else if (state != S_IDLE && rx_valid)
                    begin
                        if (frame_len == MAX_FRAME)
                        begin
                            err_long <= 1'b1; // RQ11
                        end
                        else
                        begin
                            frame_len <= frame_len + 9'h001;
                        end
                        if (state == S_BODY)
                        begin
                            rx_sum <= rx_sum + rx_data; // RQ14
                        end
                        if (in_body && !err_long)
                        begin
                            body_len <= body_len + 9'h001;
                            case (body_len)
                                9'h000: st_hi <= rx_data;
                                9'h001: st_lo <= rx_data;
                                9'h002: req_cmd <= rx_data;
                                9'h003: ct_hi <= rx_data;
                                9'h004: ct_lo <= rx_data;
                                default: ;
                            endcase
                        end
                        if (state == S_BODY && got_eot && with_chk)
                        begin
                            state <= S_CHK_HI; // RQ2 RQ12
                        end
                        else if (state == S_CHK_HI)
                        begin
                            chk_hi <= hex_value(rx_data);
                            state <= S_CHK_LO;
                        end
                        else if (finish)
                        begin
                            req_len <= rx_addr[7:0];
                            if (!station_ok)
                            begin
                                state <= S_IDLE; // RQ15
                            end
                            else if (is_bad)
                            begin
                                nak <= 1'b1; // RQ4
                                err_code <= rx_err;
                                state <= S_SEND;
                                pos <= 9'h000;
                                tx_sum <= RESET_BYTE;
                                rd_ok <= 1'b0;
                            end
                            else
                            begin
                                req_valid <= 1'b1;
                                state <= S_WAIT;
                            end
                        end
                    end
                end
                S_WAIT:
                begin
                    // Application decides the kind of answer
                    if (ans_start)
                    begin
                        nak <= !ans_ok; // RQ3 RQ4
                        err_code <= ans_err;
                        data_len <= ans_fit;
                        state <= S_SEND;
                        pos <= 9'h000;
                        tx_sum <= RESET_BYTE;
                        rd_ok <= 1'b0;
                    end
                end
                S_SEND:
                begin
                    // Data bytes wait one cycle for the registered memory read
                    if (in_data && !rd_ok)
                    begin
                        rd_ok <= 1'b1;
                    end
                    if (push)
                    begin
                        rd_ok <= 1'b0;
                        pos <= pos + 9'h001;
                        if (pos <= pos_etx)
                        begin
                            tx_sum <= tx_sum + tx_byte; // RQ14
                        end
                        if (pos == last_pos)
                        begin
                            state <= S_IDLE; // RQ12
                        end
                    end
                end
                default:
                begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // --------------------
    // Line drive and status
    // --------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            bus_drive_en <= 1'b0;
            busy <= 1'b0;
            req_type <= 16'h0000;
        end
        else
        begin
            // Shared bus is released once the last byte has left
            bus_drive_en <= chan2 ? (state == S_SEND || tx_valid) : 1'b1; // RQ13
            busy <= state != S_IDLE;
            req_type <= {ct_hi, ct_lo};
        end
    end

endmodule : ascii_serial_slave_framer

//--- tb/framer_monitor.sv
/* Checker on the framer's ports.
   Bound to every framer instance; one clock domain. */
`timescale 1ns/1ns
module framer_monitor
    import framer_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Watched ports
    input wire logic chan2,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic bus_drive_en,
    input wire logic req_valid,
    input wire logic [7:0] req_cmd,
    input wire logic ans_start,
    input wire logic ans_ok,
    input wire logic busy
);
    // --------------------
    // Properties
    // --------------------
    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    AST_ACK_HEAD:
    assert property (ans_start && ans_ok && busy && !tx_valid |-> ##[1:3]
        (tx_valid && tx_data == CODE_ACK)) else $error("ack header missing");
    AST_NAK_HEAD:
    assert property (ans_start && !ans_ok && busy && !tx_valid |-> ##[1:3]
        (tx_valid && tx_data == CODE_NAK)) else $error("nak header missing");
    AST_REQ_PULSE:
    assert property (req_valid |=> !req_valid && busy) else $error("request pulse wrong");
    AST_REQ_CLOSE:
    assert property (req_valid && req_cmd < 8'h61 |-> $past(rx_valid)
        && $past(rx_data) == CODE_EOT) else $error("request not closed by tail");
    AST_CMD_HOLD:
    assert property (req_valid |=> $stable(req_cmd)) else $error("command not held");
    AST_TX_HOLD:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("stalled byte changed");
    AST_BUS_CH1:
    assert property (!chan2 && !$past(chan2) && !$past(srst) |-> bus_drive_en)
        else $error("point to point line not driven");
    AST_BUS_CH2:
    assert property (chan2 && $past(chan2) && $past(tx_valid) |-> bus_drive_en)
        else $error("shared bus not driven while sending");

    // Main scenarios reached
    COV_ACK: cover property (tx_valid && tx_ready && tx_data == CODE_ACK);
    COV_NAK: cover property (tx_valid && tx_ready && tx_data == CODE_NAK);
    COV_STALL: cover property (tx_valid && !tx_ready ##1 tx_valid && tx_ready);
endmodule : framer_monitor

bind ascii_serial_slave_framer framer_monitor u_monitor (.clock(clock), .srst(srst),
    .chan2(chan2), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .bus_drive_en(bus_drive_en),
    .req_valid(req_valid), .req_cmd(req_cmd), .ans_start(ans_start),
    .ans_ok(ans_ok), .busy(busy));

//--- tb/serial_master_model.sv
/* Serial master model: sends request frames, takes response bytes.
   Assumes the framer samples rx bytes on rising clock edges. */
`timescale 1ns/1ns
module serial_master_model
    import framer_pkg::*;
(
    // Clock and stall mode
    input wire logic clock,
    input wire logic stall_en,
    // Request bytes
    output logic rx_valid,
    output logic [7:0] rx_data,
    // Response byte acceptance
    output logic tx_ready
);
    logic [7:0] sum;
    logic [1:0] phase;

    // Idle line values
    initial
    begin
        rx_valid = 1'b0;
        rx_data = 8'hFF;
        tx_ready = 1'b1;
        phase = 2'h0;
    end

    // Slow mode takes one byte in three
    always @(posedge clock)
    begin
        phase <= #1 (phase == 2'h2) ? 2'h0 : phase + 2'h1;
        tx_ready <= #1 !stall_en || phase == 2'h0;
    end

    // Nibble to upper-case hex character
    function automatic logic [7:0] hx(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction : hx

    // One byte per clock, back to back
    task automatic put(input logic [7:0] b);
        @(posedge clock);
        #1;
        rx_valid = 1'b1;
        rx_data = b;
        sum = sum + b;
    endtask : put

    // Whole request frame; bad flips the check
    task automatic send_frame(input logic [7:0] st, input logic [7:0] cmd,
        input logic [15:0] typ, input logic [7:0] d[$], input logic bad);
        logic [7:0] chk;
        sum = 8'h00;
        put(CODE_ENQ);
        put(hx(st[7:4]));
        put(hx(st[3:0]));
        put(cmd);
        put(typ[15:8]);
        put(typ[7:0]);
        foreach (d[i]) put(d[i]);
        put(CODE_EOT);
        chk = sum ^ {7'h00, bad};
        if (cmd >= 8'h61)
        begin
            put(hx(chk[7:4]));
            put(hx(chk[3:0]));
        end
        @(posedge clock);
        #1;
        rx_valid = 1'b0;
        rx_data = ~rx_data;
    endtask : send_frame
endmodule : serial_master_model

//--- tb/ascii_serial_slave_framer_bench.sv
/* Self-checking bench for the ASCII serial slave framer.
   Far side is the serial master model; response bytes checked from a queue. */
`timescale 1ns/1ns
module ascii_serial_slave_framer_bench import framer_pkg::*;;
    logic clock, srst, chan2, rx_valid, tx_valid, tx_ready, bus_drive_en, req_valid;
    logic ans_wr, ans_start, ans_ok, busy, stall_en;
    logic [7:0] own_station, rx_data, tx_data, req_cmd, req_len, req_rd_addr, req_rd_data;
    logic [7:0] ans_addr, ans_wdata, ans_len;
    logic [15:0] req_type, ans_err;
    logic [7:0] exp_q[$];
    integer seed = 39639;
    integer miscompares = 0;
    integer checks = 0;
    integer cycles = 0;
    integer req_count = 0;

    // --------------------
    // Clock, parts and checking
    // --------------------
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    ascii_serial_slave_framer u_dut (.clock(clock), .srst(srst), .own_station(own_station),
        .chan2(chan2), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .bus_drive_en(bus_drive_en),
        .req_valid(req_valid), .req_cmd(req_cmd), .req_type(req_type), .req_len(req_len),
        .req_rd_addr(req_rd_addr), .req_rd_data(req_rd_data), .ans_wr(ans_wr),
        .ans_addr(ans_addr), .ans_wdata(ans_wdata), .ans_start(ans_start), .ans_ok(ans_ok),
        .ans_len(ans_len), .ans_err(ans_err), .busy(busy));
    serial_master_model u_master (.clock(clock), .stall_en(stall_en), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_ready(tx_ready));

    task automatic check8(input string what, input logic [7:0] exp, got);
        checks++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            miscompares++;
        end
    endtask : check8

    task automatic complete_run();
        $display("checks %0d, miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    // Count requests, compare taken bytes, cut a hang short
    always @(posedge clock)
    begin
        cycles++;
        if (req_valid)
            req_count++;
        if (tx_valid && tx_ready)
        begin
            if (exp_q.size() != 0)
                check8("tx_data", exp_q.pop_front(), tx_data);
            else
                check8("stray tx_data", ~tx_data, tx_data);
        end
        if (cycles == 20000)
        begin
            miscompares++;
            complete_run();
        end
    end

    // Random hex character
    function automatic logic [7:0] rh();
        return u_master.hx(4'($random(seed)));
    endfunction : rh

    // Notes a whole response: echo, body, tail, optional check
    task automatic note_resp(input logic [7:0] head, input logic [7:0] cmd,
        input logic [15:0] typ, input logic [7:0] body[$]);
        logic [7:0] f[$];
        logic [7:0] s;
        f = {head, u_master.hx(own_station[7:4]), u_master.hx(own_station[3:0]), cmd};
        f = {f, typ[15:8], typ[7:0], body, CODE_ETX};
        s = 8'h00;
        foreach (f[i]) s += f[i];
        if (cmd >= 8'h61)
            f = {f, u_master.hx(s[7:4]), u_master.hx(s[3:0])};
        exp_q = {exp_q, f};
    endtask : note_resp

    // One request; the application answers when it is accepted
    task automatic run(input logic [7:0] st, input logic [7:0] cmd, input logic [15:0] typ,
        input int n, input logic [15:0] dev_err, input logic ok, input int alen);
        logic [7:0] d[$];
        logic [7:0] a[$];
        logic [7:0] eb[$];
        logic [15:0] e;
        int base;
        int acc;
        base = req_count;
        acc = (st == own_station && dev_err == 16'h0000) ? 1 : 0;
        e = (dev_err != 16'h0000) ? dev_err : 16'($random(seed));
        for (int i = 3; i >= 0; i--) eb.push_back(u_master.hx(e[4 * i +: 4]));
        for (int i = 0; i < n; i++) d.push_back(rh());
        if (st == own_station && dev_err != 16'h0000)
            note_resp(CODE_NAK, cmd, typ, eb);
        u_master.send_frame(st, cmd, typ, d, dev_err == ERR_CHECK);
        if (acc == 1)
        begin
            for (int i = 0; i < 40 && req_count == base; i++)
            begin
                @(posedge clock);
                #1;
            end
            check8("req_cmd", cmd, req_cmd);
            check8("req_len", 8'(n), req_len);
            check8("req_type hi", typ[15:8], req_type[15:8]);
            check8("req_type lo", typ[7:0], req_type[7:0]);
            foreach (d[i])
            begin
                req_rd_addr = 8'(i);
                @(posedge clock);
                #1;
                check8("req_rd_data", d[i], req_rd_data);
            end
            for (int i = 0; i < alen; i++)
            begin
                a.push_back(rh());
                ans_wr = 1'b1;
                ans_addr = 8'(i);
                ans_wdata = a[i];
                @(posedge clock);
                #1;
            end
            ans_wr = 1'b0;
            note_resp(ok ? CODE_ACK : CODE_NAK, cmd, typ, ok ? a : eb);
            ans_ok = ok;
            ans_len = 8'(alen);
            ans_err = e;
            ans_start = 1'b1;
            @(posedge clock);
            #1;
            ans_start = 1'b0;
        end
        for (int i = 0; i < 3000 && (exp_q.size() != 0 || busy); i++)
        begin
            @(posedge clock);
            #1;
        end
        check8("pending bytes", 8'h00, 8'(exp_q.size()));
        check8("req_count", 8'(base + acc), 8'(req_count));
    endtask : run

    // --------------------
    // Main sequence
    // --------------------
    initial
    begin
        srst = 1'b1;
        chan2 = 1'b0;
        stall_en = 1'b0;
        own_station = 8'h3C;
        req_rd_addr = 8'h00;
        {ans_wr, ans_start, ans_ok} = 3'h0;
        {ans_addr, ans_wdata, ans_len} = 24'h000000;
        ans_err = 16'h0000;
        repeat (5) @(posedge clock);
        #1;
        srst = 1'b0;
        run(8'h3C, 8'h52, 16'h5353, 4, 16'h0000, 1'b1, 3);
        stall_en = 1'b1;
        run(8'h3C, 8'h72, 16'h5342, 2, 16'h0000, 1'b1, 0);
        run(8'h3C, 8'h72, 16'h5353, 2, ERR_CHECK, 1'b1, 0);
        run(8'h3C, 8'h57, 16'h5342, 249, 16'h0000, 1'b1, 2);
        run(8'h3C, 8'h57, 16'h5342, 250, ERR_TOO_LONG, 1'b1, 0);
        chan2 = 1'b1;
        run(8'h3C, 8'h78, 16'h3030, 0, 16'h0000, 1'b0, 0);
        run(8'h3D, 8'h52, 16'h5353, 1, 16'h0000, 1'b1, 1);
        complete_run();
    end
endmodule : ascii_serial_slave_framer_bench
